// ===== verilog/sdp_pkg.sv
// Shared constants and types for the synchronous DRAM pin link and its controller.
package sdp_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Pin widths of the memory link.
	localparam int DQ_W = 32;
	localparam int ADDR_W = 11;
	localparam int BA_W = 2;
	localparam int DQM_W = 4;
	localparam int COL_W = 8;
	localparam int NBANK = 4;
	localparam int LANE_W = 8;
	localparam int PRE_SEL_BIT = 10; // Position of precharge_select_bit on the address.
	localparam int MASK_LAT = 2; // Read mask to output disable, in clocks.

	////////////////////////////////////////////////////////////////////////////////
	// Mode word fields held by the memory.
	localparam int MODE_BL_LSB = 0;
	localparam int MODE_CL_LSB = 4;
	localparam logic [10:0] MODE_RESET = 11'h022;
	localparam logic [2:0] BL_CODE_MAX = 3'h3;

	// Commands as {chip select, row strobe, column strobe, write strobe}, all active low.
	typedef enum logic [3:0] {
		CMD_LMR = 4'b0000,
		CMD_REF = 4'b0001,
		CMD_PRE = 4'b0010,
		CMD_ACT = 4'b0011,
		CMD_WR = 4'b0100,
		CMD_RD = 4'b0101,
		CMD_BST = 4'b0110,
		CMD_NOP = 4'b0111
	} sdp_cmd_t;

	// Power and clock states of the memory.
	typedef enum logic [2:0] {
		PWR_RUN = 3'b000,
		PWR_PD_PRE = 3'b001,
		PWR_PD_ACT = 3'b010,
		PWR_SELF = 3'b011,
		PWR_SUSP = 3'b100
	} sdp_pwr_t;

	////////////////////////////////////////////////////////////////////////////////
	// Controller register map, byte addresses on the Avalon-MM slave.
	localparam int AVS_ADDR_W = 5;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_CMD = 5'h04;
	localparam logic [4:0] REG_WDATA = 5'h08;
	localparam logic [4:0] REG_MASK = 5'h0C;
	localparam logic [4:0] REG_RDATA = 5'h10;
	localparam logic [4:0] REG_STATUS = 5'h14;
	localparam int CTRL_CKE_BIT = 0;
	localparam int CTRL_CL_LSB = 4;
	localparam int CTRL_WB_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0021;
	localparam int CMDR_CODE_LSB = 0;
	localparam int CMDR_BA_LSB = 4;
	localparam int CMDR_ADDR_LSB = 8;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_RDV_BIT = 1;

endpackage

// ===== verilog/sdp_bus_if.sv
// Pin bundle between the DRAM controller and the memory, with data bus resolution.
`timescale 1ns/1ps
interface sdp_bus_if (
	input logic clk_sys
);
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [sdp_pkg::BA_W-1:0] ba;
	logic [sdp_pkg::ADDR_W-1:0] addr;
	logic [sdp_pkg::DQM_W-1:0] dqm;
	logic [sdp_pkg::DQ_W-1:0] ctl_dq_out;
	logic ctl_dq_oe;
	logic [sdp_pkg::DQ_W-1:0] mem_dq_out;
	logic [sdp_pkg::DQM_W-1:0] mem_dq_oe;
	logic [sdp_pkg::DQ_W-1:0] dq;

	// Each byte lane of the shared bus follows whichever end enables it; an idle lane reads 0.
	always_comb begin
		for (int l = 0; l < sdp_pkg::DQM_W; l++) begin
			if (mem_dq_oe[l]) begin
				dq[l*sdp_pkg::LANE_W +: sdp_pkg::LANE_W] = mem_dq_out[l*sdp_pkg::LANE_W +: sdp_pkg::LANE_W];
			end else if (ctl_dq_oe) begin
				dq[l*sdp_pkg::LANE_W +: sdp_pkg::LANE_W] = ctl_dq_out[l*sdp_pkg::LANE_W +: sdp_pkg::LANE_W];
			end else begin
				dq[l*sdp_pkg::LANE_W +: sdp_pkg::LANE_W] = 8'h00;
			end
		end
	end

	modport ctl (
		input clk_sys,
		output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq_out, ctl_dq_oe,
		input dq
	);

	modport mem (
		input clk_sys, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
		output mem_dq_out, mem_dq_oe
	);
endinterface

// ===== verilog/sdp_ctl.sv
// DRAM controller end: Avalon-MM registers that issue single pin commands.
`timescale 1ns/1ps
module sdp_ctl (
	input logic clk_sys,
	input logic rst,
	input logic [sdp_pkg::AVS_ADDR_W-1:0] avs_address,
	input logic avs_read,
	input logic avs_write,
	input logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	sdp_bus_if.ctl bus
);
	logic [31:0] ctrl;
	logic [31:0] cmd_reg;
	logic [31:0] wdata;
	logic [31:0] mask;
	logic [31:0] rdata;
	logic rd_valid;
	logic [3:0] pins;
	logic [3:0] wcnt;
	logic [2:0] rcnt;
	logic commit_wr;
	logic commit_rd;
	logic busy;

	////////////////////////////////////////////////////////////////////////////////
	// An access is committed on the one edge at which waitrequest is seen low.
	assign commit_wr = avs_write && !avs_waitrequest;
	assign commit_rd = avs_read && !avs_waitrequest;
	assign busy = (wcnt != 4'h0) || bus.ctl_dq_oe || (rcnt != 3'h0);

	// Every access waits exactly one cycle, so read data can come from a flop.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	// Read data is loaded during the wait cycle and stands at the commit edge.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			case (avs_address)
				sdp_pkg::REG_CTRL: avs_readdata <= ctrl;
				sdp_pkg::REG_CMD: avs_readdata <= cmd_reg;
				sdp_pkg::REG_WDATA: avs_readdata <= wdata;
				sdp_pkg::REG_MASK: avs_readdata <= mask;
				sdp_pkg::REG_RDATA: avs_readdata <= rdata;
				sdp_pkg::REG_STATUS: avs_readdata <= {30'h0, rd_valid, busy};
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Software registers; the mask register drives the byte mask pins directly.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl <= sdp_pkg::CTRL_RESET;
			cmd_reg <= 32'h0000_0000;
			wdata <= 32'h0000_0000;
			mask <= 32'h0000_0000;
		end else if (commit_wr) begin
			case (avs_address)
				sdp_pkg::REG_CTRL: ctrl <= avs_writedata;
				sdp_pkg::REG_CMD: cmd_reg <= avs_writedata;
				sdp_pkg::REG_WDATA: wdata <= avs_writedata;
				sdp_pkg::REG_MASK: mask <= {28'h000_0000, avs_writedata[3:0]};
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command pins carry a command for one cycle after a CMD write, else no-operation.
	// Any command may go to any bank at any time, so software can overlap banks.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pins <= sdp_pkg::CMD_NOP;
			bus.ba <= 2'h0;
			bus.addr <= 11'h000;
		end else if (commit_wr && avs_address == sdp_pkg::REG_CMD) begin
			pins <= avs_writedata[sdp_pkg::CMDR_CODE_LSB +: 4]; // RULE19 RULE18
			bus.ba <= avs_writedata[sdp_pkg::CMDR_BA_LSB +: sdp_pkg::BA_W]; // RULE12
			bus.addr <= avs_writedata[sdp_pkg::CMDR_ADDR_LSB +: sdp_pkg::ADDR_W]; // RULE13 RULE14 RULE15 RULE16
		end else begin
			pins <= sdp_pkg::CMD_NOP; // RULE19
		end
	end

	assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = pins; // RULE8
	assign bus.dqm = mask[sdp_pkg::DQM_W-1:0]; // RULE11
	assign bus.cke = ctrl[sdp_pkg::CTRL_CKE_BIT]; // RULE3

	////////////////////////////////////////////////////////////////////////////////
	// Write data is driven beside a WRITE and for the programmed extra beats only.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus.ctl_dq_oe <= 1'b0;
			bus.ctl_dq_out <= 32'h0000_0000;
			wcnt <= 4'h0;
		end else if (commit_wr && avs_address == sdp_pkg::REG_CMD
				&& avs_writedata[3:0] == sdp_pkg::CMD_WR) begin
			bus.ctl_dq_oe <= 1'b1; // RULE17
			bus.ctl_dq_out <= wdata;
			wcnt <= ctrl[sdp_pkg::CTRL_WB_LSB +: 4];
		end else if (wcnt != 4'h0) begin
			wcnt <= wcnt - 4'h1;
		end else begin
			bus.ctl_dq_oe <= 1'b0; // RULE20
		end
	end

	// The first read beat is caught a read latency after the READ reaches the pins.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rcnt <= 3'h0;
			rdata <= 32'h0000_0000;
		end else if (commit_wr && avs_address == sdp_pkg::REG_CMD
				&& avs_writedata[3:0] == sdp_pkg::CMD_RD) begin
			rcnt <= {1'b0, ctrl[sdp_pkg::CTRL_CL_LSB +: 2]} + 3'h1;
		end else if (rcnt != 3'h0) begin
			rcnt <= rcnt - 3'h1;
			if (rcnt == 3'h1) begin
				rdata <= bus.dq; // RULE17
			end
		end
	end

	// Sticky read-valid flag; a new capture wins over a clearing read of RDATA.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_valid <= 1'b0;
		end else if (rcnt == 3'h1) begin
			rd_valid <= 1'b1;
		end else if (commit_rd && avs_address == sdp_pkg::REG_RDATA) begin
			rd_valid <= 1'b0;
		end
	end
endmodule

// ===== verilog/sdp_mem.sv
// Memory end: command decode, banks, bursts, masking and clock gating of the DRAM.
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
// Function
// RULE1: All pins sampled on rising clock edge only.
// RULE2: Each edge advances burst column and output registers.
// RULE3: Clock gate low picks power-down, self refresh, suspend.
// RULE4: Gate watched every edge while powered down.
// RULE5: Inputs ignored during power-down and self refresh.
// RULE6: Commands taken only with chip select low.
// RULE7: Bursts and masking continue with chip select high.
// RULE8: Command decoded from four strobes on one edge.
// RULE9: Masked write lanes keep old data.
// RULE10: Masked read lanes disabled two clocks later.
// RULE11: Mask bit n covers data byte lane n.
// RULE12: Bank select chooses the target bank.
// RULE13: ACTIVE opens row from all address lines.
// RULE14: Column from low address; bit ten requests autoprecharge.
// RULE15: PRECHARGE bit ten closes all banks.
// RULE16: Mode command loads mode word from address.
// RULE17: One shared 32-bit data bus both ways.
// RULE18: Controller may precharge one bank while using another.
// RULE19: Controller issues standard commands, no-operation when idle.
// RULE20: Controller releases data bus when not writing.
module sdp_mem #(
	parameter int ROW_KEEP = 2
) (
	input logic clk_sys,
	input logic rst,
	sdp_bus_if.mem bus,
	output sdp_pkg::sdp_pwr_t pwr_state,
	output logic [sdp_pkg::NBANK-1:0] bank_open,
	output logic [sdp_pkg::ADDR_W-1:0] mode_word
);
	localparam int IDX_W = sdp_pkg::BA_W + ROW_KEEP + sdp_pkg::COL_W;
	localparam int DEPTH = 2 ** IDX_W;

	// Only the low row bits are kept, so rows alias; the array stays small for simulation.
	logic [sdp_pkg::DQ_W-1:0] mem [0:DEPTH-1];
	logic [sdp_pkg::ADDR_W-1:0] row_addr [0:sdp_pkg::NBANK-1];
	logic b_act;
	logic b_wr;
	logic b_ap;
	logic [sdp_pkg::BA_W-1:0] b_bank;
	logic [sdp_pkg::COL_W-1:0] b_col;
	logic [3:0] b_left;
	logic [sdp_pkg::DQ_W-1:0] sd_d [0:1];
	logic [1:0] sd_v;
	logic [sdp_pkg::DQM_W-1:0] dqm_d1;
	logic [sdp_pkg::DQM_W-1:0] dqm_d2;
	sdp_pkg::sdp_cmd_t cmd;
	logic clk_run;
	logic cmd_ok;
	logic is_rw;
	logic beat;
	logic cur_wr;
	logic cur_ap;
	logic last;
	logic [sdp_pkg::BA_W-1:0] cur_bank;
	logic [sdp_pkg::COL_W-1:0] cur_col;
	logic [3:0] bl;
	logic [2:0] cl;
	logic [IDX_W-1:0] cur_idx;
	logic [sdp_pkg::DQ_W-1:0] cur_data;

	////////////////////////////////////////////////////////////////////////////////
	// Burst length in beats from the mode code; unsupported codes fall back to one beat.
	function automatic logic [3:0] burst_len(input logic [2:0] code);
		if (code > sdp_pkg::BL_CODE_MAX) begin
			return 4'h1;
		end
		return 4'(4'h1 << code);
	endfunction

	// Next column, wrapping inside the aligned block of one burst length.
	function automatic logic [7:0] next_col(input logic [7:0] col, input logic [3:0] len);
		logic [7:0] m;
		m = {4'h0, len} - 8'h01;
		return (col & ~m) | ((col + 8'h01) & m);
	endfunction

	// Word index of a bank, row and column in the folded array.
	function automatic logic [IDX_W-1:0] word_idx(input logic [1:0] bank,
			input logic [10:0] row, input logic [7:0] col);
		return {bank, row[ROW_KEEP-1:0], col};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// The internal clock runs only while powered up and the gate pin is high.
	assign clk_run = (pwr_state == sdp_pkg::PWR_RUN) && bus.cke; // RULE3 RULE5
	assign cmd = sdp_pkg::sdp_cmd_t'({bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n}); // RULE8
	assign cmd_ok = clk_run && !bus.cs_n; // RULE6
	assign is_rw = cmd_ok && (cmd == sdp_pkg::CMD_RD || cmd == sdp_pkg::CMD_WR);
	assign bl = burst_len(mode_word[sdp_pkg::MODE_BL_LSB +: 3]);
	assign cl = mode_word[sdp_pkg::MODE_CL_LSB +: 3];

	// Pick the beat of this edge: a new READ or WRITE, else the running burst.
	always_comb begin
		beat = 1'b0;
		cur_wr = b_wr;
		cur_ap = b_ap;
		cur_bank = b_bank;
		cur_col = b_col;
		last = 1'b0;
		if (is_rw) begin
			beat = 1'b1;
			cur_wr = (cmd == sdp_pkg::CMD_WR);
			cur_ap = bus.addr[sdp_pkg::PRE_SEL_BIT]; // RULE14
			cur_bank = bus.ba; // RULE12
			cur_col = bus.addr[sdp_pkg::COL_W-1:0]; // RULE14
			last = (bl == 4'h1);
		end else if (clk_run && b_act && !(cmd_ok && cmd == sdp_pkg::CMD_BST)) begin
			beat = 1'b1; // RULE7
			last = (b_left == 4'h1);
		end
	end

	assign cur_idx = word_idx(cur_bank, row_addr[cur_bank], cur_col);
	assign cur_data = mem[cur_idx];

	////////////////////////////////////////////////////////////////////////////////
	// Write beats store only the lanes whose mask pin is low.
	always_ff @(posedge clk_sys) begin
		if (beat && cur_wr) begin
			for (int l = 0; l < sdp_pkg::DQM_W; l++) begin
				if (!bus.dqm[l]) begin // RULE9 RULE11
					mem[cur_idx][l*sdp_pkg::LANE_W +: sdp_pkg::LANE_W] <=
						bus.dq[l*sdp_pkg::LANE_W +: sdp_pkg::LANE_W]; // RULE1 RULE17
				end
			end
		end
	end

	// Burst column counter; a new READ or WRITE cuts the running burst short.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			b_act <= 1'b0;
			b_wr <= 1'b0;
			b_ap <= 1'b0;
			b_bank <= 2'h0;
			b_col <= 8'h00;
			b_left <= 4'h0;
		end else if (is_rw) begin
			b_act <= (bl != 4'h1);
			b_wr <= cur_wr;
			b_ap <= cur_ap;
			b_bank <= cur_bank;
			b_col <= next_col(cur_col, bl); // RULE2
			b_left <= bl - 4'h1;
		end else if (cmd_ok && cmd == sdp_pkg::CMD_BST) begin
			b_act <= 1'b0;
		end else if (beat) begin
			b_col <= next_col(b_col, bl); // RULE2
			b_left <= b_left - 4'h1;
			b_act <= !last;
		end
	end

	// Bank rows, auto precharge at burst end, and the remaining commands.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bank_open <= 4'h0;
			mode_word <= sdp_pkg::MODE_RESET;
			for (int b = 0; b < sdp_pkg::NBANK; b++) begin
				row_addr[b] <= 11'h000;
			end
		end else begin
			if (beat && last && cur_ap) begin
				bank_open[cur_bank] <= 1'b0; // RULE14
			end
			if (cmd_ok) begin
				case (cmd)
					sdp_pkg::CMD_ACT: begin
						bank_open[bus.ba] <= 1'b1; // RULE12
						row_addr[bus.ba] <= bus.addr; // RULE13
					end
					sdp_pkg::CMD_PRE: begin
						if (bus.addr[sdp_pkg::PRE_SEL_BIT]) begin
							bank_open <= 4'h0; // RULE15
						end else begin
							bank_open[bus.ba] <= 1'b0; // RULE15
						end
					end
					sdp_pkg::CMD_LMR: mode_word <= bus.addr; // RULE16
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power state. Exit is checked on every edge, since the gate pin is the only
	// input still listened to while the buffers are off; a real part exits without
	// a clock, which a single-clock model can only approximate.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pwr_state <= sdp_pkg::PWR_RUN;
		end else begin
			case (pwr_state)
				sdp_pkg::PWR_RUN: begin
					if (!bus.cke) begin
						if (b_act || (|sd_v)) begin
							pwr_state <= sdp_pkg::PWR_SUSP; // RULE3
						end else if (!bus.cs_n && cmd == sdp_pkg::CMD_REF) begin
							pwr_state <= sdp_pkg::PWR_SELF; // RULE3
						end else if (|bank_open) begin
							pwr_state <= sdp_pkg::PWR_PD_ACT; // RULE3
						end else begin
							pwr_state <= sdp_pkg::PWR_PD_PRE; // RULE3
						end
					end
				end
				sdp_pkg::PWR_PD_PRE, sdp_pkg::PWR_PD_ACT, sdp_pkg::PWR_SELF: begin
					if (bus.cke) begin
						pwr_state <= sdp_pkg::PWR_RUN; // RULE4 RULE5
					end
				end
				sdp_pkg::PWR_SUSP: begin
					if (bus.cke) begin
						pwr_state <= sdp_pkg::PWR_RUN; // RULE3
					end
				end
				default: pwr_state <= sdp_pkg::PWR_RUN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read pipeline and mask delay; both freeze while the internal clock is held.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sd_v <= 2'b00;
			sd_d[0] <= 32'h0000_0000;
			sd_d[1] <= 32'h0000_0000;
			dqm_d1 <= 4'h0;
			dqm_d2 <= 4'h0;
		end else if (clk_run) begin
			sd_v <= {sd_v[0], beat && !cur_wr}; // RULE2
			sd_d[0] <= cur_data;
			sd_d[1] <= sd_d[0];
			dqm_d1 <= bus.dqm; // RULE7
			dqm_d2 <= dqm_d1;
		end
	end

	// Output registers: data from the stage that matches the read latency, each lane
	// turned off by the mask seen two edges earlier.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus.mem_dq_out <= 32'h0000_0000;
			bus.mem_dq_oe <= 4'h0;
		end else if (clk_run) begin
			case (cl)
				3'h1: begin
					bus.mem_dq_out <= cur_data;
					bus.mem_dq_oe <= {4{beat && !cur_wr}} & ~dqm_d2; // RULE10 RULE11
				end
				3'h3: begin
					bus.mem_dq_out <= sd_d[1];
					bus.mem_dq_oe <= {4{sd_v[1]}} & ~dqm_d2; // RULE10
				end
				default: begin
					bus.mem_dq_out <= sd_d[0];
					bus.mem_dq_oe <= {4{sd_v[0]}} & ~dqm_d2; // RULE10 RULE17
				end
			endcase
		end else if (pwr_state != sdp_pkg::PWR_SUSP && !(pwr_state == sdp_pkg::PWR_RUN)) begin
			bus.mem_dq_oe <= 4'h0;
		end
	end
endmodule

// ===== verification/sdp_checker.sv
// Pin-level assertions on the link between the DRAM controller and the memory.
`timescale 1ns/1ps
module sdp_checker (
	input logic clk_sys,
	input logic rst,
	input logic cke,
	input logic cs_n,
	input logic ras_n,
	input logic cas_n,
	input logic we_n,
	input logic [1:0] ba,
	input logic [10:0] addr,
	input logic [3:0] dqm,
	input logic ctl_dq_oe,
	input logic [3:0] mem_dq_oe
);
	logic [3:0] cmd;

	// The four strobes read as one command code.
	assign cmd = {cs_n, ras_n, cas_n, we_n};

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	////////////////////////////////////////
	// Controller side: idle after reset, one-cycle commands, steady address.
	reset_idle_a: assert property ($fell(rst) |-> cke && cmd == 4'h7 && !ctl_dq_oe)
		else $error("pins not idle after reset");
	cmd_pulse_a: assert property (cmd != 4'h7 |=> cmd == 4'h7)
		else $error("command held longer than one cycle");
	addr_hold_a: assert property (cmd == 4'h7 && $past(cmd) == 4'h7 |-> $stable(addr) && $stable(ba))
		else $error("address moved without a command");
	write_drive_a: assert property ($rose(ctl_dq_oe) |-> cmd == sdp_pkg::CMD_WR)
		else $error("controller drove data without a write");

	////////////////////////////////////////
	// Memory side: read latency, mask latency and no fight on the shared bus.
	no_fight_a: assert property (ctl_dq_oe |-> mem_dq_oe == 4'h0)
		else $error("both ends drive the data bus");
	read_mask_a: assert property (dqm != 4'h0 |-> ##3 (mem_dq_oe & $past(dqm, 3)) == 4'h0)
		else $error("masked lane still driven two clocks on");
	read_start_a: assert property (cmd == sdp_pkg::CMD_RD && cke && $past(cke) &&
		dqm == 4'h0 && $past(dqm) == 4'h0 |-> ##2 mem_dq_oe == 4'hF)
		else $error("read data not driven at latency two");
	read_cause_a: assert property ($rose(|mem_dq_oe) |->
		$past(cmd, 2) == sdp_pkg::CMD_RD || $past(dqm, 4) != 4'h0)
		else $error("memory drove the bus without a read");
endmodule

// ===== verification/sdr_dram_pin_command_interface_test.sv
// Self-checking bench for the controller and memory joined pin to pin.
`timescale 1ns/1ps
module sdr_dram_pin_command_interface_test;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	sdp_pkg::sdp_pwr_t pwr_state;
	logic [3:0] bank_open;
	logic [10:0] mode_word;
	logic [31:0] seed = 32'hEA2B7C48;
	logic [31:0] rd;
	int n_mismatch = 0;
	int samples_checked = 0;

	sdp_bus_if u_sdp_bus_if (.clk_sys(clk_sys));
	sdp_ctl u_sdp_ctl (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus(u_sdp_bus_if.ctl));
	sdp_mem #(.ROW_KEEP(2)) u_sdp_mem (.clk_sys(clk_sys), .rst(rst), .bus(u_sdp_bus_if.mem),
		.pwr_state(pwr_state), .bank_open(bank_open), .mode_word(mode_word));
	sdp_checker u_sdp_checker (.clk_sys(clk_sys), .rst(rst), .cke(u_sdp_bus_if.cke),
		.cs_n(u_sdp_bus_if.cs_n), .ras_n(u_sdp_bus_if.ras_n), .cas_n(u_sdp_bus_if.cas_n),
		.we_n(u_sdp_bus_if.we_n), .ba(u_sdp_bus_if.ba), .addr(u_sdp_bus_if.addr),
		.dqm(u_sdp_bus_if.dqm), .ctl_dq_oe(u_sdp_bus_if.ctl_dq_oe),
		.mem_dq_oe(u_sdp_bus_if.mem_dq_oe));

	// Free-running system clock, 10 ns period.
	always #5 clk_sys = ~clk_sys;

	////////////////////////////////////////
	// Random source; a fixed start keeps every run alike.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Byte mask spread over the data lanes, bit n over bits 8n+7..8n.
	function automatic logic [31:0] lanes(input logic [3:0] m);
		for (int l = 0; l < 4; l++) lanes[l*8 +: 8] = {8{m[l]}};
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One Avalon cycle; an extra edge after release keeps strobes from being set twice at once.
	task automatic avs(input logic wr, input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk_sys);
		// No local limit here: only the watchdog may end a wait that never finishes.
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk_sys);
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Register write, then enough edges for the memory to act on it.
	task automatic put(input logic [4:0] a, input logic [31:0] d);
		avs(1'b1, a, d);
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [10:0] a);
		put(sdp_pkg::REG_CMD, {13'h0, a, 2'h0, b, c});
	endtask

	task automatic wrmem(input logic [1:0] b, input logic [10:0] a, input logic [31:0] d,
		input logic [3:0] m);
		put(sdp_pkg::REG_MASK, {28'h0, m});
		put(sdp_pkg::REG_WDATA, d);
		cmd(sdp_pkg::CMD_WR, b, a);
	endtask

	task automatic rdmem(input logic [1:0] b, input logic [10:0] a, input logic [3:0] m);
		put(sdp_pkg::REG_MASK, {28'h0, m});
		cmd(sdp_pkg::CMD_RD, b, a);
		avs(1'b0, sdp_pkg::REG_STATUS, 32'h0);
		chk("status", 32'h2, {30'h0, rd[1:0]});
		avs(1'b0, sdp_pkg::REG_RDATA, 32'h0);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	////////////////////////////////////////
	// Main sequence: reset, mode, banks, data with masks, precharge, cs and power.
	initial begin
		logic [31:0] d0;
		logic [31:0] exp;
		logic [3:0] m;
		logic [1:0] b;
		logic [10:0] col;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk("mode", {21'h0, sdp_pkg::MODE_RESET}, {21'h0, mode_word});
		avs(1'b0, sdp_pkg::REG_CTRL, 32'h0);
		chk("ctrl", sdp_pkg::CTRL_RESET, rd);
		avs(1'b0, 5'h1C, 32'h0);
		chk("unmapped", 32'h0, rd);
		// Every supported burst code, 3 down to 0; the last one left is a single beat.
		for (int i = 3; i >= 0; i--) begin
			cmd(sdp_pkg::CMD_LMR, 2'h0, 11'h020 | 11'(i));
			chk("mode", {21'h0, 11'h020 | 11'(i)}, {21'h0, mode_word});
		end
		for (int i = 0; i < 4; i++) begin
			cmd(sdp_pkg::CMD_ACT, 2'(i), 11'(rnd()));
			chk("open", 32'((2 << i) - 1), {28'h0, bank_open});
		end
		// Masked write over old data, then plain and masked reads; single lanes first.
		for (int i = 0; i < 12; i++) begin
			b = 2'(rnd());
			col = {3'h0, 8'(rnd())};
			d0 = rnd();
			m = (i < 4) ? 4'(1 << i) : 4'(rnd());
			exp = rnd();
			wrmem(b, col, d0, 4'h0);
			wrmem(b, col, exp, m);
			exp = (d0 & lanes(m)) | (exp & ~lanes(m));
			rdmem(b, col, 4'h0);
			chk("merge", exp, rd);
			rdmem(b, col, m);
			chk("rmask", exp & ~lanes(m), rd);
		end
		put(sdp_pkg::REG_MASK, 32'h0);
		// Four-beat write burst driven for four cycles; a deselected READ lands on its last
		// beat, so a decoder that ignored chip select would cut the burst one word short.
		d0 = rnd();
		cmd(sdp_pkg::CMD_LMR, 2'h0, 11'h022);
		put(sdp_pkg::REG_CTRL, 32'h321);
		put(sdp_pkg::REG_WDATA, d0);
		avs(1'b1, sdp_pkg::REG_CMD, {13'h0, 11'h004, 2'h0, 2'h3, sdp_pkg::CMD_WR});
		avs(1'b1, sdp_pkg::REG_CMD, {28'h0, 4'hD});
		cmd(sdp_pkg::CMD_LMR, 2'h0, 11'h020);
		put(sdp_pkg::REG_CTRL, 32'h21);
		for (int k = 0; k < 4; k++) begin
			rdmem(2'h3, 11'(4 + k), 4'h0);
			chk("burst", d0, rd);
		end
		cmd(sdp_pkg::CMD_WR, 2'h1, 11'h400 | col);
		chk("autopre", 32'hD, {28'h0, bank_open});
		cmd(sdp_pkg::CMD_PRE, 2'h2, 11'h000);
		chk("pre_one", 32'h9, {28'h0, bank_open});
		cmd(4'hB, 2'h2, 11'h000);
		chk("cs_high", 32'h9, {28'h0, bank_open});
		put(sdp_pkg::REG_CTRL, 32'h20);
		chk("pd_act", {29'h0, sdp_pkg::PWR_PD_ACT}, {29'h0, pwr_state});
		cmd(sdp_pkg::CMD_ACT, 2'h1, 11'h000);
		put(sdp_pkg::REG_CTRL, 32'h21);
		chk("run", {29'h0, sdp_pkg::PWR_RUN}, {29'h0, pwr_state});
		chk("pd_ignore", 32'h9, {28'h0, bank_open});
		cmd(sdp_pkg::CMD_PRE, 2'h0, 11'h400);
		chk("pre_all", 32'h0, {28'h0, bank_open});
		put(sdp_pkg::REG_CTRL, 32'h20);
		chk("pd_pre", {29'h0, sdp_pkg::PWR_PD_PRE}, {29'h0, pwr_state});
		put(sdp_pkg::REG_CTRL, 32'h21);
		chk("run", {29'h0, sdp_pkg::PWR_RUN}, {29'h0, pwr_state});
		final_report();
	end

	// Watchdog, far beyond the roughly 1100 cycles the sequence needs.
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		final_report();
	end
endmodule
